// *** tlsd_defines.vh ***
// Register offsets, field positions, reset values and timing counts of the shutdown logic.
`ifndef TLSD_DEFINES_VH
`define TLSD_DEFINES_VH
`define TLSD_OFS_CONFIG 8'h00
`define TLSD_OFS_ONESHOT 8'h04
`define TLSD_OFS_CONSEC 8'h08
`define TLSD_OFS_HYST 8'h0C
`define TLSD_OFS_SUMMARY 8'h10
`define TLSD_OFS_HIGH_STAT 8'h14
`define TLSD_OFS_LOW_STAT 8'h18
`define TLSD_OFS_SHDN_EN 8'h1C
`define TLSD_OFS_HW_THRESH 8'h20
`define TLSD_OFS_BETA 8'h24
`define TLSD_OFS_ALERT_MASK 8'h28
`define TLSD_BLK_HIGH 3'h2
`define TLSD_BLK_LOW 3'h3
`define TLSD_BLK_CRIT 3'h4
`define TLSD_BLK_HIGH_ALIAS 3'h5
`define TLSD_CFG_COMPARATOR 0
`define TLSD_CFG_MASK_ALL 1
`define TLSD_CFG_RUN_HALT 2
`define TLSD_CFG_SER_CORR 3
`define TLSD_CFG_ANTIPAR 4
`define TLSD_CFG_AUTO_BETA 5
`define TLSD_CFG_EXT_RANGE 6
`define TLSD_CONFIG_RST 7'h28
`define TLSD_ALERT_CNT_RST 3'h1
`define TLSD_CRIT_CNT_RST 3'h4
`define TLSD_HYST_RST 8'h0A
`define TLSD_HIGH_RST 8'h55
`define TLSD_LOW_RST 8'h00
`define TLSD_CRIT_RST 8'h64
`define TLSD_BETA_DIODE 4'hF
`define TLSD_THR_BASE 8'h4D
`define TLSD_THR_STEP_SHDN 8'h06
`define TLSD_HW_HYST 8'h0A
`define TLSD_EXT_OFFSET 8'h40
`define TLSD_CODE_MAX 3'h5
`define TLSD_CODE_BAD 3'h7
`endif

// *** tlsd_top.v ***
// Limit checking, alert, critical and hardware shutdown logic with an APB register file.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tlsd_defines.vh"

// Notes on behaviour
// - Sensed pull-up resistor maps to 3-bit code.
// - Combined code: shutdown code high, alert low.
// - Threshold 77 plus 6 and 1 per step.
// - Channel one at threshold for count asserts shutdown.
// - Hardware shutdown releases below threshold minus ten.
// - Enabled channels over critical assert shutdown.
// - Shutdown variant forbids standby and single conversion.
// - Reading above high limit sets high status.
// - Reading at or below low sets low, outside comparator mode.
// - Aliased limit reads and writes identically everywhere.
// - Standby limit writes apply from next conversion.
// - High summary follows; read clears high bits.
// - Low summary follows; read clears low bits.
// - Alert needs status bit and consecutive count.
// - Status sticky until read, except high status in comparator mode.
// - Over critical asserts critical or shutdown pin.
// - Critical pin unmasked, releases below limit minus hysteresis.
// - Auto detection writes beta at conversion start.
// - User beta channels one, two; antiparallel forces diode.
// - Beta code 1111b selects plain diode mode.
// - Shutdown variant locks channel one beta and correction.
// - Comparator high bits ignore reads, clear with pin.
module tlsd_top #(
  parameter NCH = 5,
  parameter SHDN_VARIANT = 1
) (
  input wire MCLK_I,
  input wire RESET_N_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [7:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output wire PREADY_O,
  output reg PSLVERR_O,
  input wire [5:0] SHDN_PULLUP_I,
  input wire [5:0] ALERT_PULLUP_I,
  input wire [NCH*8-1:0] TEMP_I,
  input wire CONV_START_I,
  input wire CONV_DONE_I,
  input wire [3:0] BETA_DETECT_CH1_I,
  input wire [3:0] BETA_DETECT_CH2_I,
  output reg CONV_REQ_O,
  output reg STANDBY_O,
  output wire ALERT_O,
  output reg ALERT_OE_O,
  output reg CRIT_O,
  output reg SHDN_O,
  output reg [3:0] BETA_CH1_O,
  output reg [3:0] BETA_CH2_O,
  output reg SER_CORR_CH1_O,
  output reg SER_CORR_OTHER_O
);
  reg [6:0] cfg;
  reg [2:0] alert_cnt_cfg;
  reg [2:0] crit_cnt_cfg;
  reg [7:0] hyst;
  reg [NCH-1:0] high_stat;
  reg [NCH-1:0] low_stat;
  reg [NCH-1:0] shdn_en;
  reg [NCH-1:0] alert_mask;
  reg [7:0] high_lim [0:NCH-1];
  reg [7:0] low_lim [0:NCH-1];
  reg [7:0] crit_lim [0:NCH-1];
  reg [7:0] high_act [0:NCH-1];
  reg [7:0] low_act [0:NCH-1];
  reg [7:0] crit_act [0:NCH-1];
  reg [2:0] shdn_code;
  reg [2:0] alert_code;
  reg strap_taken;
  reg [NCH-1:0] clr_high;
  reg [NCH-1:0] clr_low;
  reg hw_state;
  reg [2:0] hw_cnt;
  reg [31:0] next_rdata;
  reg next_slverr;
  reg [7:0] thresh;
  wire [NCH-1:0] set_high;
  wire [NCH-1:0] set_low;
  wire [NCH-1:0] comp_state;
  wire [NCH-1:0] crit_state;
  integer k;
  integer m;

  wire cmp_mode = cfg[`TLSD_CFG_COMPARATOR];
  wire ext_range = cfg[`TLSD_CFG_EXT_RANGE];
  wire setup = PSEL_I & ~PENABLE_I;
  wire wr = PSEL_I & PENABLE_I & PWRITE_I;
  wire rd = PSEL_I & PENABLE_I & ~PWRITE_I;
  wire [2:0] blk = PADDR_I[7:5];
  wire [2:0] idx = PADDR_I[4:2];
  wire lim_blk = (blk == `TLSD_BLK_HIGH) || (blk == `TLSD_BLK_LOW) ||
                 (blk == `TLSD_BLK_CRIT) || (blk == `TLSD_BLK_HIGH_ALIAS);
  wire lim_ok = lim_blk && (idx < NCH) && (PADDR_I[1:0] == 2'b00);
  wire conv_start = CONV_START_I | CONV_REQ_O;
  wire [3:0] alert_n = (alert_cnt_cfg == 3'h0) ? 4'h1 : {1'b0, alert_cnt_cfg};
  wire [3:0] crit_n = (crit_cnt_cfg == 3'h0) ? 4'h1 : {1'b0, crit_cnt_cfg};

  assign PREADY_O = 1'b1;
  assign ALERT_O = 1'b0;

  // One-hot resistor sense to code; anything else is flagged as invalid.
  function [2:0] tlsd_res_code;
    input [5:0] sense;
    begin
      case (sense)
        6'h01: tlsd_res_code = 3'h0;
        6'h02: tlsd_res_code = 3'h1;
        6'h04: tlsd_res_code = 3'h2;
        6'h08: tlsd_res_code = 3'h3;
        6'h10: tlsd_res_code = 3'h4;
        6'h20: tlsd_res_code = 3'h5;
        default: tlsd_res_code = `TLSD_CODE_BAD;
      endcase
    end
  endfunction

  wire [5:0] comb_code = {shdn_code, alert_code};

  // The pull-ups are sampled once, in the first cycle after reset release.
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      shdn_code <= 3'h0;
      alert_code <= 3'h0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      shdn_code <= tlsd_res_code(SHDN_PULLUP_I);
      alert_code <= tlsd_res_code(ALERT_PULLUP_I);
      strap_taken <= 1'b1;
    end
  end

  // Unlisted codes fall back to the lowest threshold, the safe side.
  always @* begin
    if (shdn_code > `TLSD_CODE_MAX || alert_code > `TLSD_CODE_MAX) begin
      thresh = `TLSD_THR_BASE;
    end else begin
      thresh = `TLSD_THR_BASE + `TLSD_THR_STEP_SHDN * {5'h00, shdn_code} +
               {5'h00, alert_code};
    end
    if (ext_range) begin
      thresh = thresh + `TLSD_EXT_OFFSET;
    end
  end

  // Read data and error are formed in the setup cycle so they come from flip-flops.
  always @* begin
    next_rdata = 32'h00000000;
    next_slverr = 1'b0;
    if (lim_ok) begin
      if (blk == `TLSD_BLK_LOW) begin
        next_rdata[7:0] = low_lim[idx];
      end else if (blk == `TLSD_BLK_CRIT) begin
        next_rdata[7:0] = crit_lim[idx];
      end else begin
        next_rdata[7:0] = high_lim[idx];
      end
    end else if (PADDR_I == `TLSD_OFS_CONFIG) begin
      next_rdata[6:0] = cfg;
    end else if (PADDR_I == `TLSD_OFS_ONESHOT) begin
      next_rdata = 32'h00000000;
    end else if (PADDR_I == `TLSD_OFS_CONSEC) begin
      next_rdata[6:0] = {crit_cnt_cfg, 1'b0, alert_cnt_cfg};
    end else if (PADDR_I == `TLSD_OFS_HYST) begin
      next_rdata[7:0] = hyst;
    end else if (PADDR_I == `TLSD_OFS_SUMMARY) begin
      next_rdata[2:0] = {CRIT_O | SHDN_O, |low_stat, |high_stat};
    end else if (PADDR_I == `TLSD_OFS_HIGH_STAT) begin
      next_rdata[NCH-1:0] = high_stat;
    end else if (PADDR_I == `TLSD_OFS_LOW_STAT) begin
      next_rdata[NCH-1:0] = low_stat;
    end else if (PADDR_I == `TLSD_OFS_SHDN_EN) begin
      next_rdata[NCH-1:0] = shdn_en;
    end else if (PADDR_I == `TLSD_OFS_HW_THRESH) begin
      next_rdata[15:0] = {thresh, 2'b00, comb_code};
    end else if (PADDR_I == `TLSD_OFS_BETA) begin
      next_rdata[7:0] = {BETA_CH2_O, BETA_CH1_O};
    end else if (PADDR_I == `TLSD_OFS_ALERT_MASK) begin
      next_rdata[NCH-1:0] = alert_mask;
    end else begin
      next_slverr = 1'b1;
    end
  end

  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PRDATA_O <= 32'h00000000;
      PSLVERR_O <= 1'b0;
      clr_high <= {NCH{1'b0}};
      clr_low <= {NCH{1'b0}};
    end else begin
      if (setup) begin
        PRDATA_O <= next_rdata;
        PSLVERR_O <= next_slverr;
      end
      // Only the bits that were actually reported get cleared on the read.
      clr_high <= {NCH{1'b0}};
      clr_low <= {NCH{1'b0}};
      if (rd && PADDR_I == `TLSD_OFS_HIGH_STAT) begin
        clr_high <= PRDATA_O[NCH-1:0];
      end
      if (rd && PADDR_I == `TLSD_OFS_LOW_STAT) begin
        clr_low <= PRDATA_O[NCH-1:0];
      end
    end
  end

  // Configuration registers and conversion requests.
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cfg <= `TLSD_CONFIG_RST;
      alert_cnt_cfg <= `TLSD_ALERT_CNT_RST;
      crit_cnt_cfg <= `TLSD_CRIT_CNT_RST;
      hyst <= `TLSD_HYST_RST;
      shdn_en <= {NCH{1'b0}};
      alert_mask <= {NCH{1'b0}};
      CONV_REQ_O <= 1'b0;
      STANDBY_O <= 1'b0;
      for (k = 0; k < NCH; k = k + 1) begin
        high_lim[k] <= `TLSD_HIGH_RST;
        low_lim[k] <= `TLSD_LOW_RST;
        crit_lim[k] <= `TLSD_CRIT_RST;
      end
    end else begin
      CONV_REQ_O <= 1'b0;
      STANDBY_O <= cfg[`TLSD_CFG_RUN_HALT];
      if (wr) begin
        if (lim_ok) begin
          if (blk == `TLSD_BLK_LOW) begin
            low_lim[idx] <= PWDATA_I[7:0];
          end else if (blk == `TLSD_BLK_CRIT) begin
            crit_lim[idx] <= PWDATA_I[7:0];
          end else begin
            high_lim[idx] <= PWDATA_I[7:0];
          end
        end else if (PADDR_I == `TLSD_OFS_CONFIG) begin
          cfg <= PWDATA_I[6:0];
          if (SHDN_VARIANT != 0) begin
            cfg[`TLSD_CFG_RUN_HALT] <= 1'b0;
          end else if (cfg[`TLSD_CFG_RUN_HALT] && !PWDATA_I[`TLSD_CFG_RUN_HALT]) begin
            CONV_REQ_O <= 1'b1;
          end
        end else if (PADDR_I == `TLSD_OFS_ONESHOT) begin
          if (SHDN_VARIANT == 0 && cfg[`TLSD_CFG_RUN_HALT]) begin
            CONV_REQ_O <= 1'b1;
          end
        end else if (PADDR_I == `TLSD_OFS_CONSEC) begin
          alert_cnt_cfg <= PWDATA_I[2:0];
          crit_cnt_cfg <= PWDATA_I[6:4];
        end else if (PADDR_I == `TLSD_OFS_HYST) begin
          hyst <= PWDATA_I[7:0];
        end else if (PADDR_I == `TLSD_OFS_SHDN_EN) begin
          shdn_en <= PWDATA_I[NCH-1:0];
        end else if (PADDR_I == `TLSD_OFS_ALERT_MASK) begin
          alert_mask <= PWDATA_I[NCH-1:0];
        end
      end
    end
  end

  // Working limits are copied at each conversion start, so writes during standby wait.
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      for (m = 0; m < NCH; m = m + 1) begin
        high_act[m] <= `TLSD_HIGH_RST;
        low_act[m] <= `TLSD_LOW_RST;
        crit_act[m] <= `TLSD_CRIT_RST;
      end
    end else if (conv_start) begin
      for (m = 0; m < NCH; m = m + 1) begin
        high_act[m] <= high_lim[m];
        low_act[m] <= low_lim[m];
        crit_act[m] <= crit_lim[m];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan
      wire [7:0] t = TEMP_I[g*8+7:g*8];
      wire is_high = t > high_act[g];
      wire is_low = t <= low_act[g];
      wire is_crit = t > crit_act[g];
      wire high_rel = ({1'b0, t} + {1'b0, hyst}) < {1'b0, high_act[g]};
      wire crit_rel = ({1'b0, t} + {1'b0, hyst}) < {1'b0, crit_act[g]};
      reg [2:0] acnt;
      reg [2:0] ccnt;
      reg cst;
      reg crst;
      wire a_hit = ({1'b0, acnt} + 4'h1) >= alert_n;
      wire c_hit = ({1'b0, ccnt} + 4'h1) >= crit_n;
      assign set_high[g] = CONV_DONE_I & ~cmp_mode & is_high & a_hit;
      assign set_low[g] = CONV_DONE_I & ~cmp_mode & is_low & a_hit;
      assign comp_state[g] = cst;
      assign crit_state[g] = crst;
      always @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          acnt <= 3'h0;
          ccnt <= 3'h0;
          cst <= 1'b0;
          crst <= 1'b0;
        end else begin
          if (!cmp_mode) begin
            cst <= 1'b0;
          end
          if (CONV_DONE_I) begin
            if (cmp_mode) begin
              // Comparator mode counts high excursions only and holds the count.
              if (cst) begin
                if (high_rel) begin
                  cst <= 1'b0;
                  acnt <= 3'h0;
                end
              end else if (is_high) begin
                acnt <= a_hit ? acnt : acnt + 3'h1;
                cst <= a_hit;
              end else begin
                acnt <= 3'h0;
              end
            end else if (is_high || is_low) begin
              acnt <= a_hit ? 3'h0 : acnt + 3'h1;
            end else begin
              acnt <= 3'h0;
            end
            if (crst) begin
              if (crit_rel) begin
                crst <= 1'b0;
                ccnt <= 3'h0;
              end
            end else if (is_crit) begin
              ccnt <= c_hit ? ccnt : ccnt + 3'h1;
              crst <= c_hit;
            end else begin
              ccnt <= 3'h0;
            end
          end
        end
      end
    end
  endgenerate

  // Status bits: set wins over a read clear in the same cycle.
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      high_stat <= {NCH{1'b0}};
      low_stat <= {NCH{1'b0}};
    end else begin
      if (cmp_mode) begin
        high_stat <= comp_state;
      end else begin
        high_stat <= (high_stat & ~clr_high) | set_high;
      end
      low_stat <= (low_stat & ~clr_low) | set_low;
    end
  end

  // Hardware shutdown watches external channel one against the strapped threshold.
  wire [7:0] t1 = TEMP_I[15:8];
  wire hw_meet = t1 >= thresh;
  wire hw_rel = ({1'b0, t1} + {1'b0, `TLSD_HW_HYST}) < {1'b0, thresh};
  wire hw_hit = ({1'b0, hw_cnt} + 4'h1) >= crit_n;
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      hw_state <= 1'b0;
      hw_cnt <= 3'h0;
    end else if (CONV_DONE_I && strap_taken) begin
      if (hw_state) begin
        if (hw_rel) begin
          hw_state <= 1'b0;
          hw_cnt <= 3'h0;
        end
      end else if (hw_meet) begin
        hw_cnt <= hw_hit ? hw_cnt : hw_cnt + 3'h1;
        hw_state <= hw_hit;
      end else begin
        hw_cnt <= 3'h0;
      end
    end
  end

  // Pins: the critical and shutdown paths ignore the alert masks; only shdn_en gates the critical channels into shutdown.
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ALERT_OE_O <= 1'b0;
      CRIT_O <= 1'b0;
      SHDN_O <= 1'b0;
    end else begin
      if (cmp_mode) begin
        ALERT_OE_O <= |(comp_state & ~alert_mask);
      end else begin
        ALERT_OE_O <= ~cfg[`TLSD_CFG_MASK_ALL] &
                      (|((high_stat | low_stat) & ~alert_mask));
      end
      if (SHDN_VARIANT != 0) begin
        CRIT_O <= 1'b0;
        SHDN_O <= hw_state | (|(crit_state & shdn_en));
      end else begin
        CRIT_O <= |crit_state;
        SHDN_O <= 1'b0;
      end
    end
  end

  // Diode settings; channel two beta is auto-loaded or user-written, and antiparallel forces it to diode.
  always @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      BETA_CH1_O <= `TLSD_BETA_DIODE;
      BETA_CH2_O <= `TLSD_BETA_DIODE;
      SER_CORR_CH1_O <= 1'b1;
      SER_CORR_OTHER_O <= 1'b1;
    end else begin
      SER_CORR_OTHER_O <= cfg[`TLSD_CFG_SER_CORR];
      SER_CORR_CH1_O <= (SHDN_VARIANT != 0) ? 1'b1 : cfg[`TLSD_CFG_SER_CORR];
      if (conv_start && (cfg[`TLSD_CFG_AUTO_BETA] || SHDN_VARIANT != 0)) begin
        BETA_CH1_O <= BETA_DETECT_CH1_I;
      end else if (wr && PADDR_I == `TLSD_OFS_BETA && SHDN_VARIANT == 0) begin
        BETA_CH1_O <= PWDATA_I[3:0];
      end
      if (cfg[`TLSD_CFG_ANTIPAR]) begin
        BETA_CH2_O <= `TLSD_BETA_DIODE;
      end else if (conv_start && cfg[`TLSD_CFG_AUTO_BETA]) begin
        BETA_CH2_O <= BETA_DETECT_CH2_I;
      end else if (wr && PADDR_I == `TLSD_OFS_BETA) begin
        BETA_CH2_O <= PWDATA_I[7:4];
      end
    end
  end
endmodule
`default_nettype wire

// *** tlsd_checker_asserts.sv ***
// Concurrent checks on the pins and register port of the shutdown logic.
`timescale 1ns/1ps
`default_nettype none
module tlsd_checker #(
  parameter NCH = 5,
  parameter SHDN_VARIANT = 1
) (
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [5:0] SHDN_PULLUP_I,
  input wire logic [5:0] ALERT_PULLUP_I,
  input wire logic CONV_DONE_I,
  input wire logic CONV_REQ_O,
  input wire logic STANDBY_O,
  input wire logic ALERT_O,
  input wire logic ALERT_OE_O,
  input wire logic CRIT_O,
  input wire logic SHDN_O,
  input wire logic SER_CORR_CH1_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  logic acc;
  logic wr;
  logic rd_thr;
  logic [5:0] exp_code;
  // A strap that is not one-hot decodes to the spare code seven.
  function automatic logic [2:0] strap_code(input logic [5:0] oh);
    strap_code = 3'h7;
    for (int i = 0; i < 6; i++) begin
      if (oh == (6'h01 << i)) strap_code = i[2:0];
    end
  endfunction
  assign acc = PSEL_I & PENABLE_I;
  assign wr = acc & PWRITE_I;
  assign rd_thr = acc & !PWRITE_I & (PADDR_I == 8'h20);
  assign exp_code = {strap_code(SHDN_PULLUP_I), strap_code(ALERT_PULLUP_I)};
  thr_code_a: assert property (rd_thr |-> PRDATA_O[5:0] == exp_code)
    else $error("combined strap code wrong");
  unmapped_err_a: assert property (acc && PADDR_I == 8'h2C |-> PSLVERR_O)
    else $error("no error for unmapped address");
  ready_high_a: assert property (PREADY_O && !ALERT_O)
    else $error("ready low or alert line driven high");
  no_standby_a: assert property (SHDN_VARIANT != 0 |-> !STANDBY_O && !CONV_REQ_O)
    else $error("standby or single conversion on shutdown part");
  crit_pin_off_a: assert property (SHDN_VARIANT != 0 |-> !CRIT_O)
    else $error("critical pin used on shutdown part");
  corr_locked_a: assert property (SHDN_VARIANT != 0 |-> SER_CORR_CH1_O)
    else $error("channel one correction switched off");
  shdn_rise_a: assert property ($rose(SHDN_O) |-> $past(CONV_DONE_I, 2))
    else $error("shutdown rose without a conversion");
  shdn_fall_a: assert property ($fell(SHDN_O) |-> $past(CONV_DONE_I, 2))
    else $error("shutdown released without a conversion");
  alert_rise_a: assert property ($rose(ALERT_OE_O) |->
    $past(CONV_DONE_I, 2) || $past(wr) || $past(wr, 2))
    else $error("alert rose without a conversion or write");
  shdn_seen_c: cover property ($rose(SHDN_O));
  release_seen_c: cover property ($fell(SHDN_O));
  alert_seen_c: cover property ($rose(ALERT_OE_O));
  slverr_seen_c: cover property (acc && PSLVERR_O);
endmodule
bind tlsd_top tlsd_checker #(.NCH(NCH), .SHDN_VARIANT(SHDN_VARIANT)) chk_u (
  .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .SHDN_PULLUP_I(SHDN_PULLUP_I), .ALERT_PULLUP_I(ALERT_PULLUP_I),
  .CONV_DONE_I(CONV_DONE_I), .CONV_REQ_O(CONV_REQ_O), .STANDBY_O(STANDBY_O),
  .ALERT_O(ALERT_O), .ALERT_OE_O(ALERT_OE_O), .CRIT_O(CRIT_O), .SHDN_O(SHDN_O),
  .SER_CORR_CH1_O(SER_CORR_CH1_O));
`default_nettype wire

// *** tlsd_sensor_model.sv ***
// Behavioural conversion front end that feeds readings and detected gain codes.
`timescale 1ns/1ps
`default_nettype none
module tlsd_sensor_model #(
  parameter NCH = 5
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic [NCH*8-1:0] temp_i,
  output logic start_o,
  output logic done_o,
  output logic busy_o,
  output logic [NCH*8-1:0] temp_o,
  output logic [3:0] beta1_o,
  output logic [3:0] beta2_o
);
  logic [2:0] step;
  // Detected gain codes are fixed so that any auto-loaded value can be predicted.
  assign beta1_o = 4'h6;
  assign beta2_o = 4'h9;
  // Readings hold only with the done pulse; the inverse outside it exposes late sampling.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step <= 3'h0;
      start_o <= 1'b0;
      done_o <= 1'b0;
      busy_o <= 1'b0;
      temp_o <= {NCH{8'h00}};
    end else begin
      start_o <= (step == 3'h1);
      done_o <= (step == 3'h3);
      if (step == 3'h3) temp_o <= temp_i;
      if (step == 3'h4) temp_o <= ~temp_o;
      if (step != 3'h0 || go_i) step <= (step == 3'h4) ? 3'h0 : step + 3'h1;
      busy_o <= (step != 3'h4) && (step != 3'h0 || go_i);
    end
  end
endmodule
`default_nettype wire

// *** tlsd_top_tb.sv ***
// Self-checking bench of the shutdown logic with its conversion front end model.
`timescale 1ns/1ps
`default_nettype none
module tlsd_top_tb;
  localparam logic [39:0] idle = {5{8'h30}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic go = 1'b0;
  logic err = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd = 32'h0;
  logic [5:0] s_pu = 6'h01;
  logic [5:0] a_pu = 6'h01;
  logic [39:0] temps = idle;
  wire [39:0] tbus;
  wire [31:0] prdata;
  wire [3:0] b1, b2, bd1, bd2;
  wire pready, pslverr, creq, stby, alert, alert_oe, crit, shdn, corr_ch1, corr_oth, cst, cdn, busy;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [19:0] thr_rows [9] = '{{3'h0, 3'h0, 6'h00, 8'h4D}, {3'h0, 3'h5, 6'h05, 8'h52},
    {3'h3, 3'h2, 6'h1A, 8'h61}, {3'h5, 3'h5, 6'h2D, 8'h70}, {3'h4, 3'h1, 6'h21, 8'h66},
    {3'h4, 3'h3, 6'h23, 8'h68}, {3'h1, 3'h4, 6'h0C, 8'h57}, {3'h2, 3'h7, 6'h17, 8'h4D},
    {3'h1, 3'h0, 6'h08, 8'h53}};
  logic [16:0] reg_rows [9] = '{{8'h00, 8'h28, 1'b0}, {8'h08, 8'h41, 1'b0},
    {8'h0C, 8'h0A, 1'b0}, {8'h40, 8'h55, 1'b0}, {8'hA0, 8'h55, 1'b0}, {8'h60, 8'h00, 1'b0},
    {8'h90, 8'h64, 1'b0}, {8'h2C, 8'h00, 1'b1}, {8'h94, 8'h00, 1'b1}};
  logic [16:0] seq_rows [16] = '{{8'h53, 8'h30, 1'b0}, {8'h53, 8'h30, 1'b0},
    {8'h53, 8'h30, 1'b0}, {8'h40, 8'h30, 1'b0}, {8'h53, 8'h30, 1'b0}, {8'h53, 8'h30, 1'b0},
    {8'h53, 8'h30, 1'b0}, {8'h53, 8'h30, 1'b1}, {8'h49, 8'h30, 1'b1}, {8'h48, 8'h30, 1'b0},
    {8'h30, 8'h65, 1'b0}, {8'h30, 8'h65, 1'b0}, {8'h30, 8'h65, 1'b0}, {8'h30, 8'h65, 1'b1},
    {8'h30, 8'h5A, 1'b1}, {8'h30, 8'h59, 1'b0}};
  tlsd_top #(.NCH(5), .SHDN_VARIANT(1)) dut_u (.MCLK_I(clk), .RESET_N_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SHDN_PULLUP_I(s_pu),
    .ALERT_PULLUP_I(a_pu), .TEMP_I(tbus), .CONV_START_I(cst), .CONV_DONE_I(cdn),
    .BETA_DETECT_CH1_I(bd1), .BETA_DETECT_CH2_I(bd2), .CONV_REQ_O(creq), .STANDBY_O(stby),
    .ALERT_O(alert), .ALERT_OE_O(alert_oe), .CRIT_O(crit), .SHDN_O(shdn), .BETA_CH1_O(b1),
    .BETA_CH2_O(b2), .SER_CORR_CH1_O(corr_ch1), .SER_CORR_OTHER_O(corr_oth));
  tlsd_sensor_model #(.NCH(5)) model_u (.clk_i(clk), .rst_n_i(rst_n), .go_i(go),
    .temp_i(temps), .start_o(cst), .done_o(cdn), .busy_o(busy), .temp_o(tbus),
    .beta1_o(bd1), .beta2_o(bd2));
  initial forever #5 clk = ~clk;
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  // Straps only change inside reset, because the design takes them once after release.
  task automatic do_reset(input logic [2:0] s, input logic [2:0] a);
    rst_n <= 1'b0;
    s_pu <= (s > 3'h5) ? 6'h03 : 6'h01 << s;
    a_pu <= (a > 3'h5) ? 6'h03 : 6'h01 << a;
    repeat (4) @(posedge clk);
    chk("reset pins", 32'h1F, {25'h0, shdn, alert_oe, b1, corr_ch1});
    rst_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic conv(input logic [39:0] t);
    temps <= t;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    while (busy === 1'b1) begin
      @(posedge clk);
      #1;
    end
    repeat (3) @(posedge clk);
  endtask
  initial begin
    foreach (thr_rows[i]) begin
      do_reset(thr_rows[i][19:17], thr_rows[i][16:14]);
      apb(1'b0, 8'h20, 32'h0);
      chk("thr code", {26'h0, thr_rows[i][13:8]}, {26'h0, rd[5:0]});
      chk("thr value", {24'h0, thr_rows[i][7:0]}, {24'h0, rd[15:8]});
    end
    foreach (reg_rows[i]) begin
      rdchk("reset value", reg_rows[i][16:9], {24'h0, reg_rows[i][8:1]});
      chk("error flag", {31'h0, reg_rows[i][0]}, {31'h0, err});
    end
    apb(1'b1, 8'hA4, 32'h5A);
    rdchk("alias high", 8'h44, 32'h5A);
    apb(1'b1, 8'h48, 32'h5B);
    rdchk("alias high", 8'hA8, 32'h5B);
    apb(1'b1, 8'h00, 32'h2C);
    apb(1'b1, 8'h04, 32'h1);
    rdchk("config", 8'h00, 32'h28);
    chk("standby", 32'h0, {31'h0, stby});
    conv({idle[39:8], 8'h55});
    chk("alert at limit", 32'h0, {31'h0, alert_oe});
    conv({idle[39:8], 8'h56});
    chk("alert", 32'h1, {31'h0, alert_oe});
    rdchk("summary", 8'h10, 32'h1);
    rdchk("high status", 8'h14, 32'h1);
    rdchk("high status", 8'h14, 32'h0);
    rdchk("summary", 8'h10, 32'h0);
    chk("alert cleared", 32'h0, {31'h0, alert_oe});
    conv({idle[39:24], 8'h00, idle[15:0]});
    rdchk("summary", 8'h10, 32'h2);
    rdchk("low status", 8'h18, 32'h4);
    rdchk("low status", 8'h18, 32'h0);
    // In comparator mode the high status follows the pin and survives reads.
    apb(1'b1, 8'h00, 32'h29);
    conv({idle[39:8], 8'h56});
    chk("comparator alert", 32'h1, {31'h0, alert_oe});
    rdchk("held status", 8'h14, 32'h1);
    rdchk("held status", 8'h14, 32'h1);
    conv({idle[39:8], 8'h4B});
    chk("hysteresis hold", 32'h1, {31'h0, alert_oe});
    conv({idle[39:8], 8'h4A});
    rdchk("released status", 8'h14, 32'h0);
    chk("comparator release", 32'h0, {31'h0, alert_oe});
    apb(1'b1, 8'h00, 32'h28);
    apb(1'b1, 8'h1C, 32'h8);
    foreach (seq_rows[i]) begin
      conv({8'h30, seq_rows[i][8:1], 8'h30, seq_rows[i][16:9], 8'h30});
      chk("shutdown", {31'h0, seq_rows[i][0]}, {31'h0, shdn});
    end
    rdchk("auto beta", 8'h24, 32'h96);
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b1, 8'h24, 32'h55);
    conv(idle);
    chk("beta pins", 32'h6F, {24'h0, b1, b2});
    chk("correction pins", 32'h2, {30'h0, corr_ch1, corr_oth});
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h24, 32'h55);
    conv(idle);
    chk("user beta", 32'h65, {24'h0, b1, b2});
    repeat (4) conv({idle[39:16], 8'h53, 8'h30});
    chk("shutdown", 32'h1, {31'h0, shdn});
    do_reset(3'h1, 3'h0);
    final_report();
  end
  // The sequence needs well under a thousand cycles, so this span only trips on a hang.
  initial begin
    #50000;
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
